// >>> logic/wl_controller.sv
// Leveling controller end: Avalon-MM registers, leveling sequence, strobe delay search
// Contract
// - Device enters leveling on enable bit 1
// - Output off bit disables device outputs
// - Leveling: termination pin switches strobes only
// - Disable write termination before leveling entry
// - Data lines undefined at leveling entry
// - Only deselect and permitted mode writes
// - Level one rank; others output off
// - Termination pin only after mode update delay
// - Strobe low, wait, then one edge
// - Strobe enable delay covers termination turn-on
// - Rising strobe samples clock, drives feedback
// - Feedback skew within skew window
// - Step delay; lock on 0-to-1 feedback
// - Strobe pulses meet minimum high/low widths
// - Exit: stop strobe, termination pin low
// - Clear enable only after termination off
// - Respect command cycle and update delay
// - Data lines undefined until exit settles
// - Each byte lane reports its own strobe
`timescale 1ns/1ns
module wl_controller #(
    parameter int CK_DIV = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Link
    wl_link_if.ctl link
);
    import wl_pkg::*;

    typedef struct packed {
        wl_pkg::ctl_e st;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] cfg;
        logic start;
        logic stop;
        logic [15:0] cnt;
        logic [7:0] ph;
        logic ck;
        logic [7:0] tap0;
        logic [7:0] tap1;
        logic [1:0] locked;
        logic [1:0] prev;
        logic [7:0] hc0;
        logic [7:0] hc1;
        logic [1:0] dqs;
        logic [1:0] dqs_oe;
        logic termination_control_pin;
        logic mrs;
        logic [2:0] mr_sel;
        logic [13:0] maddr;
        logic wreq;
        logic [1:0] dqs_n;
    } ctl_s;

    ctl_s s_r;
    ctl_s s_nxt;
    logic wr_hit;
    logic [1:0] fb;

    always_comb begin
        s_nxt = s_r;
        s_nxt.mrs = 1'b0;
        s_nxt.cnt = s_r.cnt + 16'h0001;
        fb = {&link.dq[15:8], &link.dq[7:0]};
        // Free-running reference clock level seen by the device
        s_nxt.ph = (s_r.ph == 8'(CK_DIV - 1)) ? 8'h00 : s_r.ph + 8'h01;
        s_nxt.ck = s_nxt.ph < 8'(CK_DIV / 2);
        // Bus: request seen, one wait cycle, then taken with waitrequest low
        wr_hit = s_r.ack & write;
        s_nxt.ack = (read | write) & ~s_r.ack;
        if ((read | write) && !s_r.ack) begin
            case (address)
                REG_CFG: s_nxt.rdata = {30'h0, s_r.cfg};
                REG_STATUS: s_nxt.rdata = {24'h0, s_r.st != C_IDLE, s_r.locked, 1'b0, s_r.st};
                REG_TAPS: s_nxt.rdata = {16'h0, s_r.tap1, s_r.tap0};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        if (wr_hit && address == REG_CFG && s_r.st == C_IDLE) begin
            s_nxt.cfg = writedata[1:0];
        end
        // Stop set wins over its clear on return to idle
        if (s_r.st == C_IDLE) begin
            s_nxt.stop = 1'b0;
        end
        if (wr_hit && address == REG_CTRL) begin
            s_nxt.start = s_r.start | writedata[CTRL_START];
            s_nxt.stop = s_nxt.stop | writedata[CTRL_STOP];
        end
        // Strobe pulse width counters per lane
        if (s_r.dqs[0]) begin
            s_nxt.hc0 = s_r.hc0 + 8'h01;
            if (s_r.hc0 == 8'(STROBE_HIGH_CYC - 1)) begin
                s_nxt.dqs[0] = 1'b0;
            end
        end
        if (s_r.dqs[1]) begin
            s_nxt.hc1 = s_r.hc1 + 8'h01;
            if (s_r.hc1 == 8'(STROBE_HIGH_CYC - 1)) begin
                s_nxt.dqs[1] = 1'b0;
            end
        end
        case (s_r.st)
            C_IDLE: begin
                if (s_r.start) begin
                    // A start written in this same cycle survives the clear
                    s_nxt.start = wr_hit && address == REG_CTRL && writedata[CTRL_START];
                    s_nxt.locked = 2'b00;
                    s_nxt.prev = 2'b11;
                    s_nxt.tap0 = 8'h00;
                    s_nxt.tap1 = 8'h00;
                    s_nxt.st = C_WRTERM;
                end
            end
            C_WRTERM: begin
                s_nxt.mrs = 1'b1;
                s_nxt.mr_sel = MR_WRTERM;
                s_nxt.maddr = 14'h0000;
                s_nxt.cnt = 16'h0000;
                s_nxt.st = C_MRD;
            end
            C_MRD: begin
                if (s_r.cnt >= 16'(MRD_CYC - 1)) begin
                    s_nxt.st = C_ENTER;
                end
            end
            C_ENTER: begin
                s_nxt.mrs = 1'b1;
                s_nxt.mr_sel = MR_LEVEL;
                s_nxt.maddr = 14'h0000;
                s_nxt.maddr[LEVEL_EN_BIT] = 1'b1;
                s_nxt.maddr[OUT_OFF_BIT] = s_r.cfg[CFG_OUT_OFF];
                s_nxt.cnt = 16'h0000;
                s_nxt.st = C_MOD;
            end
            C_MOD: begin
                if (s_r.cnt >= 16'(MOD_CYC - 1)) begin
                    s_nxt.termination_control_pin = s_r.cfg[CFG_USE_ODT] & ~s_r.cfg[CFG_OUT_OFF];
                    s_nxt.cnt = 16'h0000;
                    s_nxt.st = s_r.cfg[CFG_OUT_OFF] ? C_HOLD : C_ODTW;
                end
            end
            C_ODTW: begin
                if (s_r.cnt >= 16'(STROBE_EN_CYC - 1)) begin
                    s_nxt.dqs_oe = 2'b11;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.st = C_PRE;
                end
            end
            C_PRE: begin
                if (s_r.cnt >= 16'(PRE_CYC - 1)) begin
                    s_nxt.cnt = 16'h0000;
                    s_nxt.st = C_PULSE;
                end
            end
            C_PULSE: begin
                // Pulses only in the first period, so each tap fires exactly once per pass
                if (s_r.ph == s_r.tap0 && !s_r.locked[0] && s_r.cnt < 16'(CK_DIV)) begin
                    s_nxt.dqs[0] = 1'b1;
                    s_nxt.hc0 = 8'h00;
                end
                if (s_r.ph == s_r.tap1 && !s_r.locked[1] && s_r.cnt < 16'(CK_DIV)) begin
                    s_nxt.dqs[1] = 1'b1;
                    s_nxt.hc1 = 8'h00;
                end
                if (s_r.cnt >= 16'(CK_DIV + STROBE_HIGH_CYC)) begin
                    s_nxt.cnt = 16'h0000;
                    s_nxt.st = C_FB;
                end
            end
            C_FB: begin
                if (s_r.cnt >= 16'(FB_OUT_CYC + SKEW_CYC + 1)) begin
                    s_nxt.prev = fb;
                    for (int i = 0; i < 2; i++) begin
                        if (!s_r.locked[i] && fb[i] && !s_r.prev[i]) begin
                            s_nxt.locked[i] = 1'b1;
                        end
                    end
                    if (!(s_r.locked[0] || (fb[0] && !s_r.prev[0]))) begin
                        s_nxt.tap0 = (s_r.tap0 == 8'(CK_DIV - 1)) ? 8'h00 : s_r.tap0 + 8'h01;
                    end
                    if (!(s_r.locked[1] || (fb[1] && !s_r.prev[1]))) begin
                        s_nxt.tap1 = (s_r.tap1 == 8'(CK_DIV - 1)) ? 8'h00 : s_r.tap1 + 8'h01;
                    end
                    s_nxt.cnt = 16'h0000;
                    s_nxt.st = (s_r.stop || &s_nxt.locked) ? C_EXIT : C_PULSE;
                end
            end
            C_HOLD: begin
                if (s_r.stop) begin
                    s_nxt.st = C_EXIT;
                end
            end
            C_EXIT: begin
                s_nxt.dqs_oe = 2'b00;
                s_nxt.termination_control_pin = 1'b0;
                s_nxt.cnt = 16'h0000;
                s_nxt.st = C_ODTOFF;
            end
            C_ODTOFF: begin
                if (s_r.cnt >= 16'(ODT_OFF_CYC - 1)) begin
                    s_nxt.st = C_LEAVE;
                end
            end
            C_LEAVE: begin
                s_nxt.mrs = 1'b1;
                s_nxt.mr_sel = MR_LEVEL;
                s_nxt.maddr = 14'h0000;
                s_nxt.maddr[OUT_OFF_BIT] = s_r.cfg[CFG_OUT_OFF];
                s_nxt.cnt = 16'h0000;
                s_nxt.st = C_DONE;
            end
            C_DONE: begin
                // Update delay is the longer wait and covers the command cycle too
                if (s_r.cnt >= 16'(MOD_CYC - 1)) begin
                    s_nxt.st = C_IDLE;
                end
            end
            default: s_nxt.st = C_IDLE;
        endcase
        // Registered copies so the bus and strobe outputs leave straight from flops
        s_nxt.wreq = ~s_nxt.ack;
        s_nxt.dqs_n = ~s_nxt.dqs;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.cfg <= CFG_RESET;
            s_r.prev <= 2'b11;
            s_r.wreq <= 1'b1;
            s_r.dqs_n <= 2'b11;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign readdata = s_r.rdata;
    assign waitrequest = s_r.wreq;
    assign link.mrs = s_r.mrs;
    assign link.mr_sel = s_r.mr_sel;
    assign link.maddr = s_r.maddr;
    assign link.termination_control_pin = s_r.termination_control_pin;
    assign link.ck_lvl = s_r.ck;
    assign link.dqs_t = s_r.dqs;
    assign link.dqs_c = s_r.dqs_n;
    assign link.dqs_oe = s_r.dqs_oe;

    if (CK_DIV < 4 || CK_DIV > 256 || CK_DIV % 2 != 0) begin
        $error("CK_DIV must be even and within 4 to 256");
    end
endmodule

// >>> logic/wl_pkg.sv
// Shared constants and types for the write-leveling device and controller ends
package wl_pkg;
    localparam int CLK_NS = 40;
    // Link timings in ns; least times round up to whole cycles
    localparam int MOD_NS = 360;
    localparam int MRD_NS = 320;
    localparam int STROBE_EN_NS = 600;
    localparam int FIRST_STROBE_NS = 400;
    localparam int STROBE_LOW_NS = 40;
    localparam int STROBE_HIGH_NS = 40;
    localparam int FB_OUT_NS = 80;
    localparam int SKEW_NS = 40;
    localparam int ODT_OFF_NS = 200;
    localparam int MOD_CYC = (MOD_NS + CLK_NS - 1) / CLK_NS;
    localparam int MRD_CYC = (MRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_EN_CYC = (STROBE_EN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRE_CYC = (STROBE_LOW_NS + FIRST_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int FB_OUT_CYC = (FB_OUT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SKEW_CYC = (SKEW_NS + CLK_NS - 1) / CLK_NS;
    localparam int ODT_OFF_CYC = (ODT_OFF_NS + CLK_NS - 1) / CLK_NS;
    // Mode register command fields
    localparam int MR_SEL_W = 3;
    localparam int ADDR_W = 14;
    localparam logic [2:0] MR_LEVEL = 3'h1;
    localparam logic [2:0] MR_WRTERM = 3'h2;
    localparam int LEVEL_EN_BIT = 7;
    localparam int OUT_OFF_BIT = 12;
    localparam int WR_TERM_LSB = 9;
    // Termination codes
    localparam logic [1:0] TERM_OFF = 2'h0;
    localparam logic [1:0] TERM_NOM = 2'h1;
    localparam logic [1:0] TERM_PARK = 2'h2;
    // Controller register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CFG = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_TAPS = 4'hC;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CFG_USE_ODT = 0;
    localparam int CFG_OUT_OFF = 1;
    localparam logic [1:0] CFG_RESET = 2'h1;
    typedef enum logic [3:0] {
        C_IDLE, C_WRTERM, C_MRD, C_ENTER, C_MOD, C_ODTW, C_PRE, C_PULSE,
        C_FB, C_HOLD, C_EXIT, C_ODTOFF, C_LEAVE, C_DONE
    } ctl_e;
endpackage

// >>> logic/wl_link_if.sv
// Link between leveling controller and memory device
`timescale 1ns/1ns
interface wl_link_if;
    logic mrs;
    logic [2:0] mr_sel;
    logic [13:0] maddr;
    logic termination_control_pin;
    logic ck_lvl;
    logic [1:0] dqs_t;
    logic [1:0] dqs_c;
    logic [1:0] dqs_oe;
    logic [15:0] dq;
    logic dq_oe;
    modport ctl (output mrs, mr_sel, maddr, termination_control_pin, ck_lvl, dqs_t, dqs_c, dqs_oe,
                 input dq, dq_oe);
    modport dev (input mrs, mr_sel, maddr, termination_control_pin, ck_lvl, dqs_t, dqs_c, dqs_oe,
                 output dq, dq_oe);
endinterface

// >>> logic/wl_device.sv
// Memory device end: leveling mode, termination and clock-sample feedback
`timescale 1ns/1ns
module wl_device (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    wl_link_if.dev link,
    // User side
    output logic leveling,
    output logic output_off,
    output logic [1:0] term_dqs,
    output logic [1:0] term_dq
);
    import wl_pkg::*;

    typedef struct packed {
        logic lvl;
        logic qoff;
        logic exiting;
        logic odt_ok;
        logic [15:0] mod_cnt;
        logic [1:0] prev_dqs;
        logic [FB_OUT_CYC-1:0] sh0;
        logic [FB_OUT_CYC-1:0] sh1;
        logic [15:0] dq;
        logic dq_oe;
        logic [1:0] tdqs;
        logic [1:0] tdq;
    } dev_s;

    dev_s s_r;
    dev_s s_nxt;
    logic [1:0] rise;

    always_comb begin
        s_nxt = s_r;
        rise = link.dqs_t & ~s_r.prev_dqs & link.dqs_oe;
        s_nxt.prev_dqs = link.dqs_t & link.dqs_oe;
        if (s_r.mod_cnt != 16'(MOD_CYC)) begin
            s_nxt.mod_cnt = s_r.mod_cnt + 16'h0001;
        end
        if (s_r.mod_cnt == 16'(MOD_CYC - 1)) begin
            s_nxt.odt_ok = s_r.lvl;
            s_nxt.exiting = 1'b0;
        end
        if (link.mrs && link.mr_sel == MR_LEVEL) begin
            s_nxt.lvl = link.maddr[LEVEL_EN_BIT];
            s_nxt.qoff = link.maddr[OUT_OFF_BIT];
            s_nxt.mod_cnt = 16'h0000;
            s_nxt.odt_ok = 1'b0;
            s_nxt.exiting = s_r.lvl & ~link.maddr[LEVEL_EN_BIT];
        end
        // Sample clock level at each rising strobe, one pipe per byte lane
        s_nxt.sh0 = {s_r.sh0[FB_OUT_CYC-2:0], rise[0] ? link.ck_lvl : s_r.sh0[0]};
        s_nxt.sh1 = {s_r.sh1[FB_OUT_CYC-2:0], rise[1] ? link.ck_lvl : s_r.sh1[0]};
        // All lines of a lane switch together, so skew stays zero
        s_nxt.dq = {{8{s_r.sh1[FB_OUT_CYC-1]}}, {8{s_r.sh0[FB_OUT_CYC-1]}}};
        // Unless output off is set, lines are driven from entry until the exit settles; value is don't-care then
        s_nxt.dq_oe = ~s_nxt.qoff & (s_nxt.lvl | s_nxt.exiting);
        if (s_r.lvl) begin
            // Next-state flag, so the pin counts from the edge the update delay ends
            s_nxt.tdqs = (s_nxt.odt_ok && link.termination_control_pin) ? TERM_NOM : TERM_PARK;
            s_nxt.tdq = TERM_OFF;
        end else begin
            s_nxt.tdqs = link.termination_control_pin ? TERM_NOM : TERM_PARK;
            s_nxt.tdq = link.termination_control_pin ? TERM_NOM : TERM_PARK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.dq = s_r.dq;
    assign link.dq_oe = s_r.dq_oe;
    assign leveling = s_r.lvl;
    assign output_off = s_r.qoff;
    assign term_dqs = s_r.tdqs;
    assign term_dq = s_r.tdq;

    if (FB_OUT_CYC < 2) begin
        $error("feedback delay must be at least two cycles");
    end
endmodule

// >>> verification/wl_link_sva.sv
// Assertions on the leveling link and the device status outputs
`timescale 1ns/1ns
module wl_link_sva
    import wl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic mrs,
    input wire logic [2:0] mr_sel,
    input wire logic [13:0] maddr,
    input wire logic termination_control_pin,
    input wire logic ck_lvl,
    input wire logic [1:0] dqs_t,
    input wire logic [1:0] dqs_c,
    input wire logic [1:0] dqs_oe,
    input wire logic [15:0] dq,
    input wire logic dq_oe,
    // Device status
    input wire logic leveling,
    input wire logic output_off,
    input wire logic [1:0] term_dqs,
    input wire logic [1:0] term_dq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic lvl_cmd;
    logic [4:0] since_r;
    logic wr_off_r;
    assign lvl_cmd = mrs && mr_sel == MR_LEVEL;
    // Saturates so that a long stay in leveling never wraps back to an early count
    always_ff @(posedge clk) begin
        if (rst) begin
            since_r <= 5'h00;
            wr_off_r <= 1'b0;
        end else begin
            since_r <= mrs ? 5'h00 : since_r + {4'h0, since_r != 5'h1F};
            wr_off_r <= (mrs && mr_sel == MR_WRTERM) ? maddr[11:9] == 3'h0 : wr_off_r;
        end
    end
    a_level_enter: assert property (
        lvl_cmd && maddr[LEVEL_EN_BIT] |=> leveling)
        else $error("leveling not entered");
    a_level_exit: assert property (
        lvl_cmd && !maddr[LEVEL_EN_BIT] |=> !leveling)
        else $error("leveling not left");
    a_output_off: assert property (
        lvl_cmd |=> output_off == $past(maddr[OUT_OFF_BIT]))
        else $error("output off does not follow command");
    a_dq_unterm: assert property (
        leveling && $past(leveling) |-> term_dq == TERM_OFF)
        else $error("data lines terminated in leveling");
    a_strobe_nom: assert property (
        leveling && $past(leveling) && termination_control_pin && $past(termination_control_pin) |-> term_dqs == TERM_NOM)
        else $error("strobe not nominal with pin high");
    a_strobe_park: assert property (
        leveling && $past(leveling) && !termination_control_pin && !$past(termination_control_pin) |-> term_dqs == TERM_PARK)
        else $error("strobe not parked with pin low");
    a_fb_lower: assert property (
        !output_off && dqs_oe[0] && $rose(dqs_t[0]) |-> ##3 dq[7:0] == {8{$past(ck_lvl, 3)}})
        else $error("lower lane feedback wrong");
    a_fb_upper: assert property (
        !output_off && dqs_oe[1] && $rose(dqs_t[1]) |-> ##3 dq[15:8] == {8{$past(ck_lvl, 3)}})
        else $error("upper lane feedback wrong");
    a_odt_after_mod: assert property (
        $rose(termination_control_pin) |-> since_r >= 5'(MOD_CYC - 1))
        else $error("termination pin raised early");
    a_wrterm_first: assert property (
        lvl_cmd && maddr[LEVEL_EN_BIT] |-> wr_off_r)
        else $error("leveling entered with write termination on");
    a_exit_odt_low: assert property (
        lvl_cmd && !maddr[LEVEL_EN_BIT] && leveling |-> !termination_control_pin && !$past(termination_control_pin, 4))
        else $error("exit command while termination on");
    a_mrs_legal: assert property (
        leveling && mrs |-> mr_sel == MR_LEVEL)
        else $error("illegal command in leveling");
    a_strobe_pair: assert property (
        dqs_c == ~dqs_t)
        else $error("strobe pair not complementary");
    c_enter: cover property (lvl_cmd && maddr[LEVEL_EN_BIT]);
    c_fb_high: cover property ($rose(dq[0]) && leveling);
    c_exit: cover property ($fell(leveling));
endmodule

// >>> verification/write_leveling_mode_tb_top.sv
// Testbench joining the leveling controller to the device end
`timescale 1ns/1ns
module write_leveling_mode_tb_top;
    import wl_pkg::*;
    localparam int DIV = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic leveling;
    logic output_off;
    logic [1:0] term_dqs;
    logic [1:0] term_dq;
    logic [31:0] rd;
    int fails = 0;
    int tests_run = 0;
    wl_link_if wl_link_if_i ();
    wl_controller #(.CK_DIV(DIV)) wl_controller_i (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link(wl_link_if_i.ctl));
    wl_device wl_device_i (.clk(clk), .rst(rst), .link(wl_link_if_i.dev),
        .leveling(leveling), .output_off(output_off), .term_dqs(term_dqs), .term_dq(term_dq));
    wl_link_sva wl_link_sva_i (.clk(clk), .rst(rst), .mrs(wl_link_if_i.mrs),
        .mr_sel(wl_link_if_i.mr_sel), .maddr(wl_link_if_i.maddr), .termination_control_pin(wl_link_if_i.termination_control_pin),
        .ck_lvl(wl_link_if_i.ck_lvl), .dqs_t(wl_link_if_i.dqs_t), .dqs_c(wl_link_if_i.dqs_c),
        .dqs_oe(wl_link_if_i.dqs_oe),
        .dq(wl_link_if_i.dq), .dq_oe(wl_link_if_i.dq_oe), .leveling(leveling),
        .output_off(output_off), .term_dqs(term_dqs), .term_dq(term_dq));
    always #20 clk = ~clk;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One Avalon access; an edge passes first so a release never meets a new request
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        check("bus answer", 32'(n < 50), 32'h1);
    endtask
    task automatic wait_lvl(input logic v);
        int n;
        for (n = 0; n < 2000 && leveling !== v; n++) @(posedge clk);
        check("leveling", 32'(leveling), 32'(v));
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[7] !== 1'b0 && n < 500);
        check("status idle", rd[7:0] & 8'h8F, 8'h00);
    endtask
    task automatic t_regs;
        bus(1'b0, REG_CFG, 32'h0);
        check("cfg reset", rd, {30'h0, CFG_RESET});
        bus(1'b0, REG_STATUS, 32'h0);
        check("status reset", rd, 32'h0);
        bus(1'b0, REG_CTRL, 32'h0);
        check("ctrl read", rd, 32'h0);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, REG_CFG, 32'h0);
        check("cfg untouched", rd, {30'h0, CFG_RESET});
    endtask
    task automatic t_level(input logic off);
        int n;
        bus(1'b1, REG_CFG, {30'h0, off, 1'b1});
        bus(1'b1, REG_CTRL, 32'h1);
        wait_lvl(1'b1);
        check("output off", 32'(output_off), 32'(off));
        @(posedge clk);
        check("dq term", 32'(term_dq), 32'(TERM_OFF));
        if (off) begin
            // A parked rank keeps its pin low, so its strobes stay on park
            repeat (MOD_CYC + 3) @(posedge clk);
            check("parked pin low", 32'(wl_link_if_i.termination_control_pin), 32'h0);
            check("strobe term", 32'(term_dqs), 32'(TERM_PARK));
            check("parked rank silent", 32'(wl_link_if_i.dq_oe), 32'h0);
            bus(1'b1, REG_CTRL, 32'h2);
        end else begin
            for (n = 0; n < 200 && wl_link_if_i.termination_control_pin !== 1'b1; n++) @(posedge clk);
            check("pin raised", 32'(wl_link_if_i.termination_control_pin), 32'h1);
            repeat (2) @(posedge clk);
            check("strobe term nominal", 32'(term_dqs), 32'(TERM_NOM));
            check("lanes driven", 32'(wl_link_if_i.dq_oe), 32'h1);
            wait_idle();
            bus(1'b0, REG_STATUS, 32'h0);
            check("lanes locked", 32'(rd[6:5]), 32'h3);
            bus(1'b0, REG_TAPS, 32'h0);
            check("lane taps agree", 32'(rd[7:0]), 32'(rd[15:8]));
            check("tap in range", 32'(rd[7:0] < 8'(DIV)), 32'h1);
        end
        wait_lvl(1'b0);
        repeat (2) @(posedge clk);
        check("park after exit", 32'(term_dqs), 32'(TERM_PARK));
        wait_idle();
    endtask
    task automatic t_stop;
        bus(1'b1, REG_CTRL, 32'h1);
        wait_lvl(1'b1);
        bus(1'b1, REG_CFG, 32'h0);
        bus(1'b0, REG_CFG, 32'h0);
        check("cfg held while busy", rd, 32'h1);
        bus(1'b1, REG_CTRL, 32'h2);
        wait_lvl(1'b0);
        wait_idle();
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Each scenario needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_level(1'b1);
        t_level(1'b0);
        t_stop();
        conclude();
    end
endmodule
